// file: rtl/lts_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "lts_regs.svh"

module lts_sequencer #(
  parameter bit HV_STARTUP = 1'b1,
  parameter int unsigned SETTLE_CYC = `LTS_SETTLE_CYC,
  parameter int unsigned REFRESH_CYC = `LTS_REFRESH_CYC,
  parameter int unsigned PAUSE_CYC = `LTS_PAUSE_CYC,
  parameter int unsigned WAKE_CYC = 400,
  parameter int unsigned OPT_SETTLE_CYC = 400,
  parameter int unsigned BOOT_CYC = 4000,
  parameter logic [11:0] STEP_MV = 12'h010,
  parameter logic [55:0] OPT_EDGES = 56'he0_c0a0_8060_4020
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire lts_pkg::lts_flags_s flags_i,
  input wire logic fb_below_threshold_i,
  input wire logic feedback_copy_below_pin_i,
  input wire logic capacitive_region_event_i,
  input wire logic pin_sinks_current_i,
  input wire logic [11:0] mirrored_target_mv_i,
  input wire logic [7:0] ratio_option_code_i,
  output lts_pkg::lts_enables_s enables_o,
  output lts_pkg::lts_phase_e pin_phase_o,
  output logic pin_pull_low_o,
  output logic pin_current_source_o,
  output logic pin_buffer_3v5_o,
  output logic pin_diode_pull_o,
  output logic control_from_pin_o,
  output logic ratio_option_current_o,
  output logic bottom_gate_drive_o,
  output logic burst_disable_o,
  output logic [11:0] burst_high_threshold_o,
  output logic [11:0] burst_low_threshold_o
);

  // --------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------
  if (SETTLE_CYC < 1 || REFRESH_CYC < 1 || PAUSE_CYC < 1 ||
      WAKE_CYC < 1 || OPT_SETTLE_CYC < 1 || BOOT_CYC < 1) begin : g_chk
    $error("All timing counts must be at least one cycle.");
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  lts_pkg::lts_sys_e sys_q;
  lts_pkg::lts_phase_e phase_q;
  logic [31:0] timer_q;
  logic [31:0] phase_timer_q;
  logic [31:0] refresh_q;
  logic [2:0] option_q;
  logic ratio_valid_q;
  logic [6:0] ratio_q;
  logic [11:0] high_q;
  logic [11:0] target_q;
  logic force_fault_q;
  logic any_fault;
  logic restart_req;
  logic timer_done;
  logic [2:0] band_opt;
  logic [11:0] high_d;
  logic [18:0] low_prod;
  logic [18:0] low_div;

  assign any_fault = flags_i.over_temp_flag | flags_i.bulk_below_stop_flag |
    flags_i.output_overvoltage_flag | flags_i.peak_current_flag |
    flags_i.avg_current_fast_flag | flags_i.avg_current_slow_flag |
    flags_i.aux_supply_undervoltage_flag | force_fault_q;
  assign restart_req = flags_i.supply_below_restart_flag;
  assign timer_done = (timer_q == 32'h0000_0000);

  // --------------------------------------------------------------------
  // Option band decode
  // --------------------------------------------------------------------
  // Each of the six low edge bytes is the upper code limit of one option band,
  // option 1 in the low byte; codes at or above the sixth edge select option 7.
  always_comb begin
    band_opt = 3'h7;
    for (int i = 5; i >= 0; i--) begin
      if (ratio_option_code_i < OPT_EDGES[i*8 +: 8]) begin
        band_opt = 3'(i + 1);
      end
    end
  end

  // --------------------------------------------------------------------
  // System state machine
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sys_q <= lts_pkg::SYS_STARTUP;
      timer_q <= 32'h0000_0000;
    end else begin
      if (!timer_done) begin
        timer_q <= timer_q - 32'h0000_0001;
      end
      case (sys_q)
        lts_pkg::SYS_STARTUP: begin
          if (flags_i.over_temp_flag) begin
            sys_q <= lts_pkg::SYS_FAULT;
            timer_q <= PAUSE_CYC;
          end else if (HV_STARTUP) begin
            sys_q <= lts_pkg::SYS_FET_ON;
          end else begin
            sys_q <= lts_pkg::SYS_FET_OFF;
          end
        end
        lts_pkg::SYS_FET_ON: begin
          if (flags_i.over_temp_flag) begin
            sys_q <= lts_pkg::SYS_FAULT;
            timer_q <= PAUSE_CYC;
          end else if (flags_i.supply_above_switch_flag && !restart_req) begin
            sys_q <= lts_pkg::SYS_FET_OFF;
          end
        end
        lts_pkg::SYS_FET_OFF, lts_pkg::SYS_WAKEUP, lts_pkg::SYS_PROGRAM,
        lts_pkg::SYS_CHARGE_BOOT: begin
          if (restart_req) begin
            sys_q <= lts_pkg::SYS_STARTUP;
          end else if (flags_i.over_temp_flag) begin
            sys_q <= lts_pkg::SYS_FAULT;
            timer_q <= PAUSE_CYC;
          end else if (sys_q == lts_pkg::SYS_FET_OFF) begin
            if (flags_i.bulk_above_start_flag &&
                !flags_i.bulk_below_stop_flag &&
                !flags_i.aux_supply_undervoltage_flag) begin
              sys_q <= lts_pkg::SYS_WAKEUP;
              timer_q <= WAKE_CYC;
            end
          end else if (sys_q == lts_pkg::SYS_WAKEUP) begin
            if (timer_done && flags_i.bulk_above_start_flag &&
                !flags_i.bulk_below_stop_flag &&
                !flags_i.aux_supply_undervoltage_flag &&
                !fb_below_threshold_i) begin
              sys_q <= lts_pkg::SYS_PROGRAM;
              timer_q <= OPT_SETTLE_CYC;
            end
          end else if (sys_q == lts_pkg::SYS_PROGRAM) begin
            if (timer_done) begin
              sys_q <= lts_pkg::SYS_CHARGE_BOOT;
              timer_q <= BOOT_CYC;
            end
          end else if (timer_done) begin
            sys_q <= lts_pkg::SYS_RUN;
          end
        end
        lts_pkg::SYS_RUN: begin
          if (restart_req) begin
            sys_q <= lts_pkg::SYS_STARTUP;
          end else if (any_fault) begin
            sys_q <= lts_pkg::SYS_FAULT;
            timer_q <= PAUSE_CYC;
          end
        end
        lts_pkg::SYS_FAULT: begin
          if (timer_done) begin
            sys_q <= lts_pkg::SYS_STARTUP;
          end
        end
        default: begin
          sys_q <= lts_pkg::SYS_STARTUP;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Ratio option capture
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      option_q <= 3'h1;
      ratio_valid_q <= 1'b0;
    end else if (sys_q == lts_pkg::SYS_STARTUP ||
                 sys_q == lts_pkg::SYS_FAULT) begin
      ratio_valid_q <= 1'b0;
    end else if (sys_q == lts_pkg::SYS_PROGRAM && timer_done &&
                 !ratio_valid_q) begin
      option_q <= band_opt;
      ratio_valid_q <= 1'b1;
    end
  end

  always_comb begin
    case (option_q)
      3'h1: ratio_q = `LTS_RATIO_OPT1;
      3'h2: ratio_q = `LTS_RATIO_OPT2;
      3'h3: ratio_q = `LTS_RATIO_OPT3;
      3'h4: ratio_q = `LTS_RATIO_OPT4;
      3'h5: ratio_q = `LTS_RATIO_OPT5;
      3'h6: ratio_q = `LTS_RATIO_OPT6;
      default: ratio_q = `LTS_RATIO_OPT7;
    endcase
  end

  // --------------------------------------------------------------------
  // Shared pin phases
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_q <= lts_pkg::PH_PULL_LOW;
      phase_timer_q <= 32'h0000_0000;
    end else if (sys_q != lts_pkg::SYS_CHARGE_BOOT &&
                 sys_q != lts_pkg::SYS_RUN) begin
      phase_q <= lts_pkg::PH_PULL_LOW;
    end else begin
      if (phase_timer_q != 32'h0000_0000) begin
        phase_timer_q <= phase_timer_q - 32'h0000_0001;
      end
      case (phase_q)
        lts_pkg::PH_PULL_LOW: begin
          phase_q <= lts_pkg::PH_INIT_PROG;
        end
        lts_pkg::PH_INIT_PROG: begin
          if (sys_q == lts_pkg::SYS_RUN) begin
            phase_q <= lts_pkg::PH_SOFTSTART;
          end
        end
        lts_pkg::PH_SOFTSTART: begin
          if (feedback_copy_below_pin_i) begin
            phase_q <= lts_pkg::PH_SETTLE;
            phase_timer_q <= SETTLE_CYC;
          end
        end
        lts_pkg::PH_SETTLE: begin
          if (phase_timer_q == 32'h0000_0001) begin
            phase_q <= lts_pkg::PH_THRESH_PROG;
          end
        end
        lts_pkg::PH_THRESH_PROG: begin
          phase_q <= lts_pkg::PH_THRESH_PROG;
        end
        default: begin
          phase_q <= lts_pkg::PH_PULL_LOW;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Burst thresholds
  // --------------------------------------------------------------------
  always_comb begin
    high_d = high_q;
    if (phase_q != lts_pkg::PH_THRESH_PROG) begin
      high_d = (option_q == `LTS_OPT_NO_BURST) ?
        `LTS_BURST_HIGH_THRESHOLD_BURST_OFF : `LTS_BURST_HIGH_THRESHOLD_NORMAL;
    end else if (refresh_q == 32'h0000_0000) begin
      if (target_q > high_q) begin
        high_d = (target_q - high_q > STEP_MV) ?
          high_q + STEP_MV : target_q;
      end else if (target_q < high_q) begin
        high_d = (high_q - target_q > STEP_MV) ?
          high_q - STEP_MV : target_q;
      end
    end
  end

  assign low_prod = {7'h00, high_d} * {12'h000, ratio_q};
  assign low_div = low_prod / `LTS_RATIO_DIV;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      refresh_q <= 32'h0000_0000;
      target_q <= `LTS_BURST_HIGH_THRESHOLD_MIN;
    end else if (phase_q != lts_pkg::PH_THRESH_PROG) begin
      refresh_q <= REFRESH_CYC - 1;
      target_q <= `LTS_BURST_HIGH_THRESHOLD_MIN;
    end else begin
      target_q <= pin_sinks_current_i ?
        mirrored_target_mv_i : `LTS_BURST_HIGH_THRESHOLD_MIN;
      refresh_q <= (refresh_q == 32'h0000_0000) ?
        REFRESH_CYC - 1 : refresh_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      high_q <= `LTS_BURST_HIGH_THRESHOLD_NORMAL;
      burst_high_threshold_o <= `LTS_BURST_HIGH_THRESHOLD_NORMAL;
      burst_low_threshold_o <= 12'h000;
    end else begin
      high_q <= high_d;
      burst_high_threshold_o <= high_d;
      burst_low_threshold_o <= low_div[11:0];
    end
  end

  // --------------------------------------------------------------------
  // Pin and enable outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enables_o <= '0;
      pin_phase_o <= lts_pkg::PH_PULL_LOW;
      pin_pull_low_o <= 1'b1;
      pin_current_source_o <= 1'b0;
      pin_buffer_3v5_o <= 1'b0;
      pin_diode_pull_o <= 1'b0;
      control_from_pin_o <= 1'b0;
      ratio_option_current_o <= 1'b0;
      bottom_gate_drive_o <= 1'b0;
      burst_disable_o <= 1'b0;
    end else begin
      enables_o.waveform_gen_enable <= (sys_q == lts_pkg::SYS_RUN);
      enables_o.softstart_enable <= (sys_q == lts_pkg::SYS_RUN);
      enables_o.aux_regulator_enable <= (sys_q != lts_pkg::SYS_STARTUP) &&
        (sys_q != lts_pkg::SYS_FET_ON) && (sys_q != lts_pkg::SYS_FAULT);
      enables_o.startup_fet_enable <= (sys_q == lts_pkg::SYS_FET_ON);
      pin_phase_o <= phase_q;
      pin_pull_low_o <= (phase_q == lts_pkg::PH_PULL_LOW) ||
        (phase_q == lts_pkg::PH_INIT_PROG &&
         option_q == `LTS_OPT_SKIP_INIT);
      pin_current_source_o <= (phase_q == lts_pkg::PH_SOFTSTART);
      control_from_pin_o <= (phase_q == lts_pkg::PH_SOFTSTART);
      pin_buffer_3v5_o <= (phase_q == lts_pkg::PH_THRESH_PROG);
      pin_diode_pull_o <= capacitive_region_event_i &&
        (sys_q == lts_pkg::SYS_RUN);
      ratio_option_current_o <= (sys_q == lts_pkg::SYS_PROGRAM);
      bottom_gate_drive_o <= (sys_q == lts_pkg::SYS_CHARGE_BOOT);
      burst_disable_o <= ratio_valid_q &&
        (option_q == `LTS_OPT_NO_BURST);
    end
  end

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      force_fault_q <= `LTS_CTRL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      // A write lands on the edge at which the master sees ack high.
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `LTS_ADDR_CTRL) begin
        force_fault_q <= wb_dat_i[`LTS_CTRL_FORCE_FAULT_BIT];
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        case (wb_adr_i)
          `LTS_ADDR_CTRL: wb_dat_o <= {31'h0000_0000, force_fault_q};
          `LTS_ADDR_STATUS: wb_dat_o <= {20'h0_0000, ratio_valid_q,
            option_q, 2'h0, phase_q, sys_q};
          `LTS_ADDR_THRESH: wb_dat_o <= {4'h0, burst_low_threshold_o,
            4'h0, burst_high_threshold_o};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/lts_regs.svh
`ifndef LTS_REGS_SVH
`define LTS_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define LTS_ADDR_CTRL 4'h0
`define LTS_ADDR_STATUS 4'h4
`define LTS_ADDR_THRESH 4'h8
`define LTS_CTRL_RESET 1'h0
`define LTS_CTRL_FORCE_FAULT_BIT 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LTS_CLK_MHZ 40
`define LTS_SETTLE_US 600
`define LTS_REFRESH_US 200
`define LTS_PAUSE_US 1000000
`define LTS_SETTLE_CYC (`LTS_SETTLE_US * `LTS_CLK_MHZ)
`define LTS_REFRESH_CYC (`LTS_REFRESH_US * `LTS_CLK_MHZ)
`define LTS_PAUSE_CYC (`LTS_PAUSE_US * `LTS_CLK_MHZ)

// ----------------------------------------------------------------------
// Thresholds in millivolts and ratios in hundredths
// ----------------------------------------------------------------------
`define LTS_BURST_HIGH_THRESHOLD_NORMAL 12'h258
`define LTS_BURST_HIGH_THRESHOLD_BURST_OFF 12'h4b0
`define LTS_BURST_HIGH_THRESHOLD_MIN 12'h064
`define LTS_RATIO_OPT1 7'h5f
`define LTS_RATIO_OPT2 7'h64
`define LTS_RATIO_OPT3 7'h5a
`define LTS_RATIO_OPT4 7'h50
`define LTS_RATIO_OPT5 7'h3c
`define LTS_RATIO_OPT6 7'h3c
`define LTS_RATIO_OPT7 7'h28
`define LTS_RATIO_DIV 19'h0_0064
`define LTS_OPT_SKIP_INIT 3'h5
`define LTS_OPT_NO_BURST 3'h7

`endif

// file: rtl/lts_pkg.sv
package lts_pkg;

  typedef enum logic [2:0] {
    SYS_STARTUP = 3'b000,
    SYS_FET_ON = 3'b001,
    SYS_FET_OFF = 3'b010,
    SYS_WAKEUP = 3'b011,
    SYS_PROGRAM = 3'b100,
    SYS_CHARGE_BOOT = 3'b101,
    SYS_RUN = 3'b110,
    SYS_FAULT = 3'b111
  } lts_sys_e;

  typedef enum logic [2:0] {
    PH_PULL_LOW = 3'b000,
    PH_INIT_PROG = 3'b001,
    PH_SOFTSTART = 3'b010,
    PH_SETTLE = 3'b011,
    PH_THRESH_PROG = 3'b100
  } lts_phase_e;

  typedef struct packed {
    logic output_overvoltage_flag;
    logic over_temp_flag;
    logic peak_current_flag;
    logic avg_current_fast_flag;
    logic avg_current_slow_flag;
    logic bulk_above_start_flag;
    logic bulk_below_stop_flag;
    logic aux_supply_undervoltage_flag;
    logic supply_below_restart_flag;
    logic supply_above_switch_flag;
    logic mains_crossing_flag;
  } lts_flags_s;

  typedef struct packed {
    logic waveform_gen_enable;
    logic aux_regulator_enable;
    logic softstart_enable;
    logic startup_fet_enable;
  } lts_enables_s;

endpackage

// file: dv/lts_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lts_checker #(
  parameter int unsigned PAUSE_CYC = 50
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire lts_pkg::lts_enables_s enables_o,
  input wire lts_pkg::lts_phase_e pin_phase_o,
  input wire logic pin_pull_low_o,
  input wire logic pin_current_source_o,
  input wire logic control_from_pin_o,
  input wire logic pin_buffer_3v5_o,
  input wire logic bottom_gate_drive_o,
  input wire logic burst_disable_o,
  input wire logic [11:0] burst_high_threshold_o,
  input wire logic [11:0] burst_low_threshold_o
);
  // Counts the length of the current stretch with every enable low.
  int unsigned zero_cnt_q;
  wire in_prog = pin_phase_o == lts_pkg::PH_THRESH_PROG;
  always_ff @(posedge clk_i) begin
    if (reset_i || enables_o != '0) begin
      zero_cnt_q <= 0;
    end else begin
      zero_cnt_q <= zero_cnt_q + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_step;
    $changed(burst_high_threshold_o) && in_prog && $past(in_prog);
  endsequence
  sequence s_hold;
    ($stable(burst_high_threshold_o) || !in_prog) [*4];
  endsequence
  a_phase_order: assert property ($changed(pin_phase_o) |->
    pin_phase_o == lts_pkg::PH_PULL_LOW ||
    3'(pin_phase_o) == 3'($past(pin_phase_o) + 3'h1))
    else $error("phase left its fixed order");
  a_pull_low_first: assert property (
    pin_phase_o == lts_pkg::PH_PULL_LOW |-> pin_pull_low_o)
    else $error("pin not pulled low in first phase");
  a_softstart_drive: assert property (
    pin_phase_o == lts_pkg::PH_SOFTSTART |->
    pin_current_source_o && control_from_pin_o && !pin_pull_low_o)
    else $error("soft start drive wrong");
  a_buffer_prog: assert property (pin_buffer_3v5_o == in_prog)
    else $error("buffer not tied to programming phase");
  a_settle_high: assert property (
    pin_phase_o == lts_pkg::PH_SETTLE &&
    $past(pin_phase_o) == lts_pkg::PH_SETTLE |->
    burst_high_threshold_o == (burst_disable_o ? 12'h4b0 : 12'h258))
    else $error("settle high threshold wrong");
  a_step_size: assert property (s_step |->
    burst_high_threshold_o <= $past(burst_high_threshold_o) + 12'h010 &&
    $past(burst_high_threshold_o) <= burst_high_threshold_o + 12'h010)
    else $error("threshold step too large");
  a_refresh_gap: assert property (s_step |=> s_hold)
    else $error("threshold refreshed too soon");
  a_low_tracks: assert property (s_step |->
    burst_low_threshold_o <= burst_high_threshold_o &&
    ($changed(burst_low_threshold_o) ||
     (burst_high_threshold_o + 12'h002 >= $past(burst_high_threshold_o) &&
      $past(burst_high_threshold_o) + 12'h002 >= burst_high_threshold_o)))
    else $error("low threshold did not follow");
  a_run_enables: assert property (enables_o.waveform_gen_enable |->
    enables_o.softstart_enable && enables_o.aux_regulator_enable &&
    !enables_o.startup_fet_enable)
    else $error("run enables inconsistent");
  a_boot_gate: assert property (bottom_gate_drive_o |->
    !enables_o.waveform_gen_enable && enables_o.aux_regulator_enable)
    else $error("bottom gate on outside boot charge");
  a_pause_len: assert property (enables_o != '0 && zero_cnt_q > 4 |->
    zero_cnt_q >= PAUSE_CYC && zero_cnt_q <= PAUSE_CYC + 3)
    else $error("fault pause length wrong");
endmodule
bind lts_sequencer lts_checker #(.PAUSE_CYC(PAUSE_CYC)) i_chk (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .enables_o(enables_o),
  .pin_phase_o(pin_phase_o),
  .pin_pull_low_o(pin_pull_low_o),
  .pin_current_source_o(pin_current_source_o),
  .control_from_pin_o(control_from_pin_o),
  .pin_buffer_3v5_o(pin_buffer_3v5_o),
  .bottom_gate_drive_o(bottom_gate_drive_o),
  .burst_disable_o(burst_disable_o),
  .burst_high_threshold_o(burst_high_threshold_o),
  .burst_low_threshold_o(burst_low_threshold_o)
);
`default_nettype wire

// file: dv/lts_network_model.sv
`timescale 1ns/1ps
`default_nettype none
module lts_network_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pin_current_source_i,
  input wire logic pin_buffer_3v5_i,
  input wire logic ratio_option_current_i,
  input wire logic [7:0] option_code_i,
  input wire logic sink_i,
  input wire logic [11:0] target_i,
  output logic feedback_copy_below_pin_o,
  output logic pin_sinks_current_o,
  output logic [11:0] mirrored_target_mv_o,
  output logic [7:0] ratio_option_code_o
);
  logic [3:0] ramp_q;
  logic [7:0] noise_q;
  // The capacitor ramps while charged; sensing is meaningless when undriven.
  always_ff @(posedge clk_i) begin
    if (reset_i || !pin_current_source_i) begin
      ramp_q <= 4'h0;
    end else if (ramp_q != 4'hf) begin
      ramp_q <= ramp_q + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    noise_q <= reset_i ? 8'h5a : ~noise_q ^ 8'h35;
  end
  assign feedback_copy_below_pin_o = ramp_q >= 4'h6;
  assign ratio_option_code_o = ratio_option_current_i ? option_code_i : noise_q;
  assign pin_sinks_current_o = pin_buffer_3v5_i ? sink_i : noise_q[0];
  assign mirrored_target_mv_o = pin_buffer_3v5_i ? target_i : {noise_q, 4'h3};
endmodule
`default_nettype wire

// file: dv/llc_startup_threshold_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module llc_startup_threshold_sequencer_tb;
  localparam int unsigned PAUSE = 50;
  logic clk_i = 0, reset_i = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000, rd;
  lts_pkg::lts_flags_s flags = '0;
  logic fb_below = 0, cap_evt = 0, sink = 0;
  logic [7:0] opt_code = 8'h00;
  logic [11:0] tgt = 12'h000;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, fcb, sinks, src_on, buf_on, opt_on, diode, bgate, bdis;
  wire logic pl, ctl;
  wire logic [11:0] mtgt, high, low;
  wire logic [7:0] ocode;
  lts_pkg::lts_enables_s enables_o;
  lts_pkg::lts_phase_e pin_phase_o;
  int n_errors = 0, n_tests = 0, q[$], n, opt, r, h, h0, t, fb;
  int ratio_tab[7] = '{95, 100, 90, 80, 60, 60, 40};
  int fbit[7] = '{10, 9, 8, 7, 6, 4, 3};
  logic [31:0] seed = 32'h0000_5fd4;
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  lts_sequencer #(.SETTLE_CYC(20), .REFRESH_CYC(10), .PAUSE_CYC(PAUSE),
    .WAKE_CYC(5), .OPT_SETTLE_CYC(5), .BOOT_CYC(5)) i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flags_i(flags),
    .fb_below_threshold_i(fb_below), .feedback_copy_below_pin_i(fcb),
    .capacitive_region_event_i(cap_evt), .pin_sinks_current_i(sinks),
    .mirrored_target_mv_i(mtgt), .ratio_option_code_i(ocode),
    .enables_o(enables_o), .pin_phase_o(pin_phase_o),
    .pin_pull_low_o(pl), .pin_current_source_o(src_on),
    .pin_buffer_3v5_o(buf_on), .pin_diode_pull_o(diode),
    .control_from_pin_o(ctl), .ratio_option_current_o(opt_on),
    .bottom_gate_drive_o(bgate), .burst_disable_o(bdis),
    .burst_high_threshold_o(high), .burst_low_threshold_o(low));
  lts_network_model i_net (.clk_i(clk_i), .reset_i(reset_i),
    .pin_current_source_i(src_on), .pin_buffer_3v5_i(buf_on),
    .ratio_option_current_i(opt_on), .option_code_i(opt_code),
    .sink_i(sink), .target_i(tgt), .feedback_copy_below_pin_o(fcb),
    .pin_sinks_current_o(sinks), .mirrored_target_mv_o(mtgt),
    .ratio_option_code_o(ocode));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask
  task automatic wait_phase(input lts_pkg::lts_phase_e p);
    int k;
    k = 0;
    do @(posedge clk_i); while (pin_phase_o !== p && ++k < 3000);
    check(32'(pin_phase_o), 32'(p));
  endtask
  task automatic wait_fet;
    n = 0;
    do @(posedge clk_i);
    while (enables_o.startup_fet_enable !== 1'b1 && ++n < 3000);
    check(32'(enables_o), 32'h0000_0001);
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    check(32'(enables_o), 32'h0000_0000);
    check({high, low}, {12'h258, 12'h000});
    reset_i <= 0;
    flags.supply_above_switch_flag <= 1;
    flags.bulk_above_start_flag <= 1;
    wait_fet;
    for (int i = 0; i < 8; i++) begin
      opt = i % 7 + 1;
      r = ratio_tab[opt-1];
      seed = xs(seed);
      opt_code <= 8'(opt * 32 - 16);
      sink <= seed[0];
      tgt <= 12'(200 + seed[15:4] % 1200);
      t = seed[0] ? 200 + seed[15:4] % 1200 : 100;
      wait_phase(lts_pkg::PH_INIT_PROG);
      check(pl, opt == 5);
      check(bgate, 1);
      check(32'(enables_o), 32'h0000_0004);
      wb(0, 4'h4, 32'h0000_0000);
      check(rd[11:8], {1'b1, 3'(opt)});
      wait_phase(lts_pkg::PH_SOFTSTART);
      check(32'(enables_o), 32'h0000_000e);
      check(ctl, 1);
      check(bdis, opt == 7);
      wait_phase(lts_pkg::PH_SETTLE);
      @(posedge clk_i);
      h = opt == 7 ? 1200 : 600;
      h0 = h;
      check(high, h);
      check(low, h * r / 100);
      while (h != t) begin
        h = h < t ? (h + 16 < t ? h + 16 : t) : (h - 16 > t ? h - 16 : t);
        q.push_back(h);
      end
      wait_phase(lts_pkg::PH_THRESH_PROG);
      n = 0;
      while (q.size() > 0 && n < 3000) begin
        if (high !== 12'(h0)) begin
          h0 = q.pop_front();
          check(high, h0);
          check(low, h0 * r / 100);
        end
        @(posedge clk_i);
        n++;
      end
      check(q.size(), 0);
      cap_evt <= 1;
      repeat (2) @(posedge clk_i);
      check(diode, 1);
      cap_evt <= 0;
      wb(0, 4'h8, 32'h0000_0000);
      check(rd, {4'h0, 12'(t * r / 100), 4'h0, 12'(t)});
      check(diode, 0);
      wb(0, 4'hc, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      fb = i == 0 ? 0 : fbit[i-1];
      if (i == 0) begin
        wb(1, 4'h0, 32'h0000_0001, 4'he);
        wb(0, 4'h0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        wb(1, 4'h0, 32'h0000_0001);
      end else begin
        flags[fb] <= 1'b1;
      end
      repeat (3) @(posedge clk_i);
      check(32'(enables_o), 32'h0000_0000);
      if (i == 0) wb(1, 4'h0, 32'h0000_0000);
      else flags[fb] <= 1'b0;
      fb_below <= 1'b1;
      wait_fet;
      check(n >= PAUSE - 6, 1);
      repeat (20) @(posedge clk_i);
      wb(0, 4'h4, 32'h0000_0000);
      check(rd[2:0], 3'b011);
      fb_below <= 1'b0;
    end
    print_verdict;
  end
endmodule
`default_nettype wire
